// ---- hdl/cfp_regs.vh ----
// constants of the clock-fail status and page-select block
// assumes a 10-bit internal address bus and 16-bit register data
`ifndef CFP_REGS_VH
`define CFP_REGS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CFP_CLOCK_FAIL_STATUS_OFS 10'h1c7
`define CFP_PAGE_SELECT_OFS 10'h3ff
`define CFP_IRQ_STATUS_OFS 10'h1d4
// ----------------------------------------------------------------
// clock-fail status fields
// ----------------------------------------------------------------
`define CFP_LOST_BIT 0
`define CFP_RETURN_BIT 1
`define CFP_HOST_IRQ_EN_BIT 2
`define CFP_CORE_IRQ_LO_BIT 3
`define CFP_CORE_IRQ_HI_BIT 6
`define CFP_DRV_DISABLE_BIT 7
`define CFP_TIMING_BIT 8
`define CFP_STATUS_RESET 16'h0000
// ----------------------------------------------------------------
// page-select values
// ----------------------------------------------------------------
`define CFP_PAGE_NONE 3'h0
`define CFP_PAGE_CODE_A 3'h1
`define CFP_PAGE_CODE_B 3'h2
`define CFP_PAGE_CODE_BOTH 3'h3
`define CFP_PAGE_COMMON 3'h4
`define CFP_PAGE_RESET 3'h0
// ----------------------------------------------------------------
// common page area windows (address bits 9:8)
// ----------------------------------------------------------------
`define CFP_AREA_DATA_A 2'h0
`define CFP_AREA_DATA_B 2'h1
`define CFP_AREA_CONFIG 2'h2
`define CFP_AREA_MAIN 2'h3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CFP_PLL_RELOCK_TIME_NS 25000
`define CFP_CLK_PERIOD_NS 20
`define CFP_RELOCK_CYCLES (`CFP_PLL_RELOCK_TIME_NS / `CFP_CLK_PERIOD_NS)
`endif

// ---- hdl/cfp_decryptor.v ----
// code stream decryptor for code ram writes
// assumes byte strobes on the system clock; keystream is a stand-in lfsr
module cfp_decryptor (
   input wire mclk,
   input wire rst_b,
   input wire restart,
   input wire byteValid,
   input wire [7:0] byteIn,
   output reg plainValid,
   output reg [7:0] plainOut
);
   reg [15:0] keyState;
   // ----------------------------------------------------------------
   // keystream state and decoded output
   // ----------------------------------------------------------------
   // restart reloads the seed so every download starts the same way
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         keyState <= 16'hace1;
         plainValid <= 1'b0;
         plainOut <= 8'h00;
      end else begin
         plainValid <= byteValid & ~restart;
         if (restart) begin
            keyState <= 16'hace1;
         end else if (byteValid) begin
            plainOut <= byteIn ^ keyState[7:0];
            keyState <= {keyState[14:0],
               keyState[15] ^ keyState[13] ^ keyState[12] ^ keyState[10]};
         end
      end
   end
endmodule // cfp_decryptor

// ---- hdl/cfp_clock_page.v ----
// clock-fail status register, page-select register and area decode
// assumes spi slave gives one-cycle rd/wr strobes with a 10-bit address;
// clock monitor inputs come from another domain and are synchronised here
//
// Operation
// - timing fault flag, write one clears
// - clock-lost flag latches until recovery completes
// - host restores clock, sets return bit
// - return bit cleared once pll switched back
// - return bit without loss clears, no pll request
// - host irq on clock absence until read
// - bits 3-6 enable four core irqs
// - bit 7 drops drivers during clock absence
// - irqs held while clock absence persists
// - irq on internal switch and return attempt
// - code ram stream always decrypted
// - decryptor restarts when code page selected
// - page zero ignores all but page register
// - pages one, two pick code ram a, b
// - page three broadcasts writes, no reads
// - values above four store as four
// - page register always reachable
// - nine area selects from address and page
// - host irq pin low, status latched
`include "cfp_regs.vh"
module cfp_clock_page (
   input wire mclk,
   input wire rst_b,
   input wire [9:0] regAddr,
   input wire regWr,
   input wire regRd,
   input wire [15:0] regWdata,
   output reg [15:0] regRdata,
   input wire refClockMissing,
   input wire timingViolation,
   input wire pllOnExternal,
   input wire codeByteValid,
   input wire [7:0] codeByte,
   output reg codeWrValid,
   output reg [7:0] codeWrData,
   output reg code_ram_a_pick,
   output reg code_ram_b_pick,
   output reg [2:0] chan_a_area_selects,
   output reg [2:0] chan_b_area_selects,
   output reg mainCfgSel,
   output reg ioCfgSel,
   output reg diagCfgSel,
   output reg accessIgnored,
   output reg returnToExtRequest,
   output reg clockOkDrvEnable,
   output reg [3:0] coreIrq,
   output reg host_irq_n,
   output reg [15:0] irqStatus
);
   // synchroniser stages for monitor inputs
   reg [2:0] missSync;
   reg [2:0] timSync;
   reg [2:0] pllSync;
   reg missing;
   reg timingSeen;
   reg onExternal;
   reg missingDly;
   // register fields
   reg ref_clock_lost_flag;
   reg return_to_ext_clock;
   reg hostIrqEnable;
   reg [3:0] coreIrqEnable;
   reg drvDisableEnable;
   reg timingFault;
   reg [2:0] pageSel;
   reg hostIrqPending;
   // decode helpers
   wire hitStatus;
   wire hitPage;
   wire hitIrqStat;
   wire returnRise;
   wire switchedInternal;
   reg [2:0] next_pageSel;
   wire pageWr;
   wire codeRestart;
   wire plainValid;
   wire [7:0] plainByte;
   reg [15:0] next_rdata;
   reg [8:0] next_areas;
   reg next_ignored;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // stored page: values above four keep only the top bit
   function [2:0] storePage;
      input [2:0] w;
      begin
         if (w[2])
            storePage = `CFP_PAGE_COMMON;
         else
            storePage = w;
      end
   endfunction

   // selects a code page (single or broadcast)
   function isCodePage;
      input [2:0] p;
      begin
         isCodePage = (p == `CFP_PAGE_CODE_A) | (p == `CFP_PAGE_CODE_B) |
            (p == `CFP_PAGE_CODE_BOTH);
      end
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   // a change counts only once stages two and three agree
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         missSync <= 3'h0;
         timSync <= 3'h0;
         pllSync <= 3'h7;
         missing <= 1'b0;
         timingSeen <= 1'b0;
         onExternal <= 1'b1;
         missingDly <= 1'b0;
      end else begin
         missSync <= {missSync[1:0], refClockMissing};
         timSync <= {timSync[1:0], timingViolation};
         pllSync <= {pllSync[1:0], pllOnExternal};
         if (missSync[1] == missSync[2])
            missing <= missSync[2];
         if (timSync[1] == timSync[2])
            timingSeen <= timSync[2];
         if (pllSync[1] == pllSync[2])
            onExternal <= pllSync[2];
         missingDly <= missing;
      end
   end

   assign hitStatus = (regAddr == `CFP_CLOCK_FAIL_STATUS_OFS);
   assign hitPage = (regAddr == `CFP_PAGE_SELECT_OFS);
   assign hitIrqStat = (regAddr == `CFP_IRQ_STATUS_OFS) &
      (pageSel == `CFP_PAGE_COMMON);
   assign pageWr = regWr & hitPage;
   assign returnRise = regWr & hitStatus & (pageSel == `CFP_PAGE_COMMON) &
      regWdata[`CFP_RETURN_BIT] & ~return_to_ext_clock;
   assign switchedInternal = missing & ~missingDly;
   assign codeRestart = pageWr & isCodePage(next_pageSel);

   always @* begin
      next_pageSel = storePage(regWdata[2:0]);
   end

   // ----------------------------------------------------------------
   // clock-fail status register
   // ----------------------------------------------------------------
   // set beats clear on every hardware-set flag
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ref_clock_lost_flag <= 1'b0;
         return_to_ext_clock <= 1'b0;
         hostIrqEnable <= 1'b0;
         coreIrqEnable <= 4'h0;
         drvDisableEnable <= 1'b0;
         timingFault <= 1'b0;
         returnToExtRequest <= 1'b0;
      end else begin
         // writable enables
         if (regWr & hitStatus & (pageSel == `CFP_PAGE_COMMON)) begin
            hostIrqEnable <= regWdata[`CFP_HOST_IRQ_EN_BIT];
            coreIrqEnable <=
               regWdata[`CFP_CORE_IRQ_HI_BIT:`CFP_CORE_IRQ_LO_BIT];
            drvDisableEnable <= regWdata[`CFP_DRV_DISABLE_BIT];
         end
         // timing fault: write one clears, new event wins
         if (timingSeen)
            timingFault <= 1'b1;
         else if (regWr & hitStatus & (pageSel == `CFP_PAGE_COMMON) &
                  regWdata[`CFP_TIMING_BIT])
            timingFault <= 1'b0;
         // lost flag held until pll is back on external
         if (switchedInternal)
            ref_clock_lost_flag <= 1'b1;
         else if (return_to_ext_clock & onExternal & ~missing)
            ref_clock_lost_flag <= 1'b0;
         // return bit acts on its rising edge only
         returnToExtRequest <= 1'b0;
         if (returnRise & ~ref_clock_lost_flag) begin
            return_to_ext_clock <= 1'b0;
         end else if (returnRise) begin
            return_to_ext_clock <= 1'b1;
            returnToExtRequest <= 1'b1;
         end else if (return_to_ext_clock & onExternal & ~missing) begin
            return_to_ext_clock <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupts and driver enable
   // ----------------------------------------------------------------
   // host request held until status read; a new event wins the read
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hostIrqPending <= 1'b0;
         coreIrq <= 4'h0;
         host_irq_n <= 1'b1;
         irqStatus <= 16'h0000;
         clockOkDrvEnable <= 1'b1;
      end else begin
         if (hostIrqEnable & (missing | switchedInternal | returnRise))
            hostIrqPending <= 1'b1;
         else if (regRd & hitStatus & (pageSel == `CFP_PAGE_COMMON))
            hostIrqPending <= 1'b0;
         // cores see it while absent; they act once the clock returns
         coreIrq <= coreIrqEnable & {4{missing | switchedInternal |
            returnRise}};
         host_irq_n <= ~hostIrqPending;
         // status frozen while pin is asserted
         if (!hostIrqPending)
            irqStatus <= 16'h0000;
         else if (host_irq_n)
            irqStatus <= 16'h0400;
         clockOkDrvEnable <= ~(drvDisableEnable & missing);
      end
   end

   // ----------------------------------------------------------------
   // page select register and area decode
   // ----------------------------------------------------------------
   // combinational area decode; registered below
   always @* begin
      next_areas = 9'h000;
      next_ignored = 1'b0;
      if ((regWr | regRd) & ~hitPage) begin
         case (pageSel)
            `CFP_PAGE_CODE_A: next_areas[1] = 1'b1;
            `CFP_PAGE_CODE_B: next_areas[4] = 1'b1;
            `CFP_PAGE_CODE_BOTH: begin
               next_areas[1] = regWr;
               next_areas[4] = regWr;
               next_ignored = regRd;
            end
            `CFP_PAGE_COMMON: begin
               case (regAddr[9:8])
                  `CFP_AREA_DATA_A: next_areas[0] = 1'b1;
                  `CFP_AREA_DATA_B: next_areas[3] = 1'b1;
                  `CFP_AREA_CONFIG: begin
                     next_areas[2] = ~regAddr[7];
                     next_areas[5] = regAddr[7];
                  end
                  default: begin
                     next_areas[6] = (regAddr[7:6] == 2'h3);
                     next_areas[7] = (regAddr[7:6] == 2'h0);
                     next_areas[8] = regAddr[7:6] == 2'h1 ||
                        regAddr[7:6] == 2'h2;
                  end
               endcase
            end
            default: next_ignored = 1'b1;
         endcase
      end
   end

   // registered selects so every output leaves a flip-flop
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pageSel <= `CFP_PAGE_RESET;
         code_ram_a_pick <= 1'b0;
         code_ram_b_pick <= 1'b0;
         chan_a_area_selects <= 3'h0;
         chan_b_area_selects <= 3'h0;
         mainCfgSel <= 1'b0;
         ioCfgSel <= 1'b0;
         diagCfgSel <= 1'b0;
         accessIgnored <= 1'b0;
      end else begin
         if (pageWr)
            pageSel <= next_pageSel;
         code_ram_a_pick <= (pageSel == `CFP_PAGE_CODE_A) |
            (pageSel == `CFP_PAGE_CODE_BOTH);
         code_ram_b_pick <= (pageSel == `CFP_PAGE_CODE_B) |
            (pageSel == `CFP_PAGE_CODE_BOTH);
         chan_a_area_selects <= next_areas[2:0];
         chan_b_area_selects <= next_areas[5:3];
         mainCfgSel <= next_areas[6];
         ioCfgSel <= next_areas[7];
         diagCfgSel <= next_areas[8];
         accessIgnored <= next_ignored;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // reserved bits read zero
   always @* begin
      next_rdata = 16'h0000;
      if (hitPage)
         next_rdata[2:0] = pageSel;
      else if (hitStatus & (pageSel == `CFP_PAGE_COMMON))
         next_rdata[8:0] = {timingFault, drvDisableEnable, coreIrqEnable,
            hostIrqEnable, return_to_ext_clock, ref_clock_lost_flag};
      else if (hitIrqStat)
         next_rdata = irqStatus;
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         regRdata <= 16'h0000;
      else if (regRd)
         regRdata <= next_rdata;
   end

   // ----------------------------------------------------------------
   // decrypted code path
   // ----------------------------------------------------------------
   // no bypass exists: code bytes always pass the decryptor
   cfp_decryptor uDecrypt (
      .mclk(mclk),
      .rst_b(rst_b),
      .restart(codeRestart),
      .byteValid(codeByteValid & isCodePage(pageSel)),
      .byteIn(codeByte),
      .plainValid(plainValid),
      .plainOut(plainByte)
   );

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         codeWrValid <= 1'b0;
         codeWrData <= 8'h00;
      end else begin
         codeWrValid <= plainValid;
         codeWrData <= plainByte;
      end
   end
endmodule // cfp_clock_page

// ---- tb/cfp_clock_page_monitor.sv ----
// port assertions for the clock-fail and page-select block
// assumes a bind onto cfp_clock_page, one clock, async low reset
`include "cfp_regs.vh"
module cfp_clock_page_monitor (
   input wire mclk,
   input wire rst_b,
   input wire [9:0] regAddr,
   input wire regWr,
   input wire regRd,
   input wire [15:0] regWdata,
   input wire codeByteValid,
   input wire codeWrValid,
   input wire code_ram_a_pick,
   input wire code_ram_b_pick,
   input wire [2:0] chan_a_area_selects,
   input wire [2:0] chan_b_area_selects,
   input wire mainCfgSel,
   input wire ioCfgSel,
   input wire diagCfgSel,
   input wire accessIgnored,
   input wire returnToExtRequest,
   input wire host_irq_n,
   input wire [15:0] irqStatus
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------------------------------
   // access decode helpers
   // ----------------------------------------------------------------
   wire pw = regWr && regAddr == `CFP_PAGE_SELECT_OFS;
   wire rw = regWr && regAddr == `CFP_CLOCK_FAIL_STATUS_OFS && regWdata[1];
   wire anyPick = code_ram_a_pick || code_ram_b_pick;
   chk_page_a: assert property (pw && regWdata[2:0] == 3'h1
      |-> ##2 code_ram_a_pick && !code_ram_b_pick) else $error("page a bad");
   chk_page_both: assert property (pw && regWdata[2:0] == 3'h3
      |-> ##2 code_ram_a_pick && code_ram_b_pick) else $error("page ab bad");
   chk_page_fold: assert property (pw && regWdata[2]
      |-> ##2 !anyPick) else $error("page fold bad");
   chk_page_reach: assert property (pw
      |-> ##1 !accessIgnored) else $error("page reg refused");
   chk_bcast_read: assert property (regRd && code_ram_a_pick
      && code_ram_b_pick && regAddr != `CFP_PAGE_SELECT_OFS
      |-> ##1 accessIgnored) else $error("read on broadcast served");
   chk_code_pass: assert property (codeByteValid && anyPick
      |-> ##2 codeWrValid) else $error("code byte lost");
   chk_code_block: assert property (codeByteValid && !anyPick
      |-> ##2 !codeWrValid) else $error("code byte off page");
   chk_sel_onehot: assert property ($onehot0({chan_a_area_selects,
      chan_b_area_selects, mainCfgSel, ioCfgSel, diagCfgSel}))
      else $error("area selects overlap");
   chk_irq_pin: assert property (irqStatus[10] |-> !host_irq_n)
      else $error("irq status without pin");
   chk_return_req: assert property (returnToExtRequest
      |-> $past(rw) || $past(rw, 2)) else $error("stray return request");
endmodule // cfp_clock_page_monitor

// ---- tb/cfp_clock_source.sv ----
// clock manager model: reference pin loss and pll switch-back
// assumes the bench commands pin loss; slow stretches the relock
module cfp_clock_source (
   input wire mclk,
   input wire rst_b,
   input wire dropRef,
   input wire slow,
   input wire returnToExtRequest,
   output reg refClockMissing,
   output reg pllOnExternal
);
   reg [3:0] waitCnt;
   // pll goes internal on loss; returns only when asked with a live pin
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         refClockMissing <= 1'b0;
         pllOnExternal <= 1'b1;
         waitCnt <= 4'h0;
      end else begin
         refClockMissing <= dropRef;
         if (dropRef) begin
            pllOnExternal <= 1'b0;
            waitCnt <= 4'h0;
         end else if (returnToExtRequest && !pllOnExternal) begin
            waitCnt <= slow ? 4'hf : 4'h2;
         end else if (waitCnt == 4'h1) begin
            pllOnExternal <= 1'b1;
            waitCnt <= 4'h0;
         end else if (waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
         end
      end
   end
endmodule // cfp_clock_source

// ---- tb/cfp_clock_page_bench.sv ----
// self-checking bench for the clock-fail and page-select block
// assumes the clock manager model and the port monitor beside it
`include "cfp_regs.vh"
module cfp_clock_page_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg mclk = 1'b0;
   reg rst_b = 1'b0;
   reg [9:0] regAddr = 10'h000;
   reg regWr = 1'b0;
   reg regRd = 1'b0;
   reg [15:0] regWdata = 16'h0000;
   reg timingViolation = 1'b0;
   reg codeByteValid = 1'b0;
   reg [7:0] codeByte = 8'h00;
   reg dropRef = 1'b0;
   reg slow = 1'b0;
   wire [15:0] regRdata, irqStatus;
   wire refClockMissing, pllOnExternal, codeWrValid, accessIgnored;
   wire code_ram_a_pick, code_ram_b_pick, mainCfgSel, ioCfgSel;
   wire diagCfgSel, returnToExtRequest, clockOkDrvEnable, host_irq_n;
   wire [2:0] chan_a_area_selects, chan_b_area_selects;
   wire [3:0] coreIrq;
   wire [7:0] codeWrData;
   reg [7:0] gotData, firstData;
   reg [15:0] rdata;
   reg [8:0] sel;
   reg ign;
   reg got;
   integer n_errors, checks, i;
   reg [9:0] ta [0:6] = '{10'h000, 10'h100, 10'h200, 10'h280,
      10'h3c0, 10'h300, 10'h340};
   reg [8:0] ts [0:6] = '{9'h001, 9'h008, 9'h004, 9'h020,
      9'h040, 9'h080, 9'h100};
   cfp_clock_page u_cfp_clock_page (.mclk, .rst_b, .regAddr, .regWr,
      .regRd, .regWdata, .regRdata, .refClockMissing, .timingViolation,
      .pllOnExternal, .codeByteValid, .codeByte, .codeWrValid,
      .codeWrData, .code_ram_a_pick, .code_ram_b_pick,
      .chan_a_area_selects, .chan_b_area_selects, .mainCfgSel, .ioCfgSel,
      .diagCfgSel, .accessIgnored, .returnToExtRequest, .clockOkDrvEnable,
      .coreIrq, .host_irq_n, .irqStatus);
   cfp_clock_source u_cfp_clock_source (.mclk, .rst_b, .dropRef, .slow,
      .returnToExtRequest, .refClockMissing, .pllOnExternal);
   initial forever #10 mclk = ~mclk;
   // ----------------------------------------------------------------
   // access tasks: strobe one cycle, capture the one-cycle answers
   // ----------------------------------------------------------------
   task chk(input string what, input [15:0] exp, input [15:0] seen);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task acc(input w, input [9:0] a, input [15:0] d);
      begin
         @(negedge mclk);
         regAddr = a;
         regWdata = d;
         regWr = w;
         regRd = !w;
         @(negedge mclk);
         regWr = 1'b0;
         regRd = 1'b0;
         sel = {diagCfgSel, ioCfgSel, mainCfgSel, chan_b_area_selects,
            chan_a_area_selects};
         ign = accessIgnored;
         rdata = regRdata;
         @(negedge mclk);
      end
   endtask
   task send(input [7:0] b);
      begin
         @(negedge mclk);
         codeByteValid = 1'b1;
         codeByte = b;
         @(negedge mclk);
         codeByteValid = 1'b0;
         @(negedge mclk);
         got = codeWrValid;
         gotData = codeWrData;
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", checks, n_errors);
         if (n_errors == 0 && checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      n_errors = 0;
      checks = 0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst_b = 1'b1;
      chk("drv en", 16'h1, {15'h0, clockOkDrvEnable});
      chk("irq pin", 16'h1, {15'h0, host_irq_n});
      acc(0, `CFP_PAGE_SELECT_OFS, 0);
      chk("page", 16'h0, rdata);
      acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
      chk("ignored", 16'h1, {15'h0, ign});
      send(8'h5a);
      chk("code off", 16'h0, {15'h0, got});
      for (i = 5; i < 8; i++) begin
         acc(1, `CFP_PAGE_SELECT_OFS, i);
         acc(0, `CFP_PAGE_SELECT_OFS, 0);
         chk("fold", 16'h4, rdata);
      end
      // code pages: picks, code select, decrypted stream
      for (i = 1; i < 4; i++) begin
         acc(1, `CFP_PAGE_SELECT_OFS, i);
         chk("picks", i, {14'h0, code_ram_b_pick, code_ram_a_pick});
         acc(0, 10'h010, 0);
         chk("code sel", i == 1 ? 2 : i == 2 ? 16'h10 : 0, sel);
         chk("rd drop", i == 3, {15'h0, ign});
         send(8'h3c);
         chk("code on", 16'h1, {15'h0, got});
         chk("no bypass", 16'h1, {15'h0, gotData != 8'h3c});
         if (i == 1)
            firstData = gotData;
         chk("restart", {8'h0, firstData}, {8'h0, gotData});
      end
      acc(1, `CFP_PAGE_SELECT_OFS, 4);
      send(8'hc3);
      chk("code cmn", 16'h0, {15'h0, got});
      for (i = 0; i < 7; i++) begin
         acc(0, ta[i], 0);
         chk("area", ts[i], sel);
      end
      // return bit with the reference healthy
      acc(1, `CFP_CLOCK_FAIL_STATUS_OFS, 16'h0002);
      acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
      chk("ret idle", 16'h0, rdata & 16'h0003);
      acc(1, `CFP_CLOCK_FAIL_STATUS_OFS, 16'h00fc);
      // loss and recovery, prompt then slow pll
      for (i = 0; i < 2; i++) begin
         slow = i[0];
         dropRef = 1'b1;
         repeat (10) @(negedge mclk);
         chk("drv off", 16'h0, {15'h0, clockOkDrvEnable});
         chk("core irq", 16'hf, {12'h0, coreIrq});
         chk("irq pin", 16'h0, {15'h0, host_irq_n});
         chk("irq stat", 16'h1, {15'h0, irqStatus[10]});
         acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
         chk("lost", 16'h00fd, rdata & 16'h01ff);
         chk("irq held", 16'h0, {15'h0, host_irq_n});
         dropRef = 1'b0;
         repeat (10) @(negedge mclk);
         chk("drv on", 16'h1, {15'h0, clockOkDrvEnable});
         acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
         chk("lost kept", 16'h1, rdata & 16'h0001);
         acc(1, `CFP_CLOCK_FAIL_STATUS_OFS, 16'h00fe);
         repeat (30) @(negedge mclk);
         acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
         chk("recover", 16'h0, rdata & 16'h0003);
         acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
         chk("irq free", 16'h1, {15'h0, host_irq_n});
         chk("core free", 16'h0, {12'h0, coreIrq});
      end
      // timing fault latch and write-one clear
      timingViolation = 1'b1;
      repeat (6) @(negedge mclk);
      timingViolation = 1'b0;
      repeat (6) @(negedge mclk);
      acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
      chk("timing", 16'h0100, rdata & 16'h0100);
      acc(1, `CFP_CLOCK_FAIL_STATUS_OFS, 16'h01fc);
      acc(0, `CFP_CLOCK_FAIL_STATUS_OFS, 0);
      chk("timing clr", 16'h00fc, rdata & 16'h01ff);
      report_and_stop;
   end
endmodule // cfp_clock_page_bench
bind cfp_clock_page cfp_clock_page_monitor u_cfp_clock_page_monitor (
   .mclk, .rst_b, .regAddr, .regWr, .regRd, .regWdata, .codeByteValid,
   .codeWrValid, .code_ram_a_pick, .code_ram_b_pick, .chan_a_area_selects,
   .chan_b_area_selects, .mainCfgSel, .ioCfgSel, .diagCfgSel,
   .accessIgnored, .returnToExtRequest, .host_irq_n, .irqStatus);
